// file: rtl/compare_action_pwm_outputs.sv
// compare output action block with APB registers
`timescale 1ns/1ps
module compare_action_pwm_outputs (
   input wire logic pclk, // apb clock, 25 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [cmp_action_pkg::ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [2:0] full_match, // timer 1 match per full unit
   input wire logic [2:0] simple_match, // match per simple unit
   input wire logic [2:0] full_wave, // raw pwm waveform per full unit
   input wire logic [2:0] simple_wave, // raw pwm waveform per simple unit
   input wire logic t1_zero, // timer 1 at zero
   input wire logic t1_period, // timer 1 at period
   input wire logic t2_zero, // timer 2 at zero
   input wire logic t2_period, // timer 2 at period
   input wire logic protect_n, // drive protection pin, active low
   output logic [5:0] full_out, // full output levels
   output logic [5:0] full_out_oe_n, // full output enable, low drives
   output logic [2:0] simple_out, // simple output levels
   output logic [2:0] simple_out_oe_n, // simple output enable, low drives
   output logic [5:0] flag_pending, // unit flags: full 2..0, simple 5..3
   output logic irq // masked flag summary
);
   import cmp_action_pkg::*;

   // =====================================================
   // apb decode
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction

   logic wr_en, rd_en, mapped;
   logic [15:0] control_q, control_d;
   logic [15:0] full_shadow_q, full_shadow_d, full_active_q, full_active_d;
   logic [15:0] simple_shadow_q, simple_shadow_d, simple_active_q, simple_active_d;
   logic [5:0] flags_q, flags_d, mask_q, mask_d;
   logic [5:0] match_d1_q, match_d2_q;
   logic [1:0] prot_sync_q;
   logic [31:0] rdata_q, rdata_d;
   logic enable;
   timer_event_if ev ();

   assign mapped = hit(paddr, COMPARE_CONTROL_IDX) | hit(paddr, FULL_ACTION_IDX) | hit(paddr, SIMPLE_ACTION_IDX)
      | hit(paddr, FLAG_STATUS_IDX) | hit(paddr, FLAG_MASK_IDX);
   // writes commit at the access edge only; reads latch in setup so prdata stands through access
   assign wr_en = psel & penable & pready & pwrite & mapped;
   assign rd_en = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign enable = control_q[ENABLE_BIT];

   // =====================================================
   // reload events
   reload_select u_full_reload (
      .sel(control_q[FULL_RELOAD_LSB +: 2]),
      .zero(t1_zero),
      .period(t1_period),
      .enable(enable),
      .load(ev.load_full)
   );
   reload_select u_simple_reload (
      .sel(control_q[SIMPLE_RELOAD_LSB +: 2]),
      .zero(control_q[SIMPLE_TIMER_BIT] ? t2_zero : t1_zero),
      .period(control_q[SIMPLE_TIMER_BIT] ? t2_period : t1_period),
      .enable(enable),
      .load(ev.load_simple)
   );
   assign ev.enable = enable;

   // =====================================================
   // registers
   always_comb begin
      control_d = control_q;
      full_shadow_d = full_shadow_q;
      simple_shadow_d = simple_shadow_q;
      mask_d = mask_q;
      if (wr_en && hit(paddr, COMPARE_CONTROL_IDX)) begin
         control_d = pwdata[15:0];
      end
      if (wr_en && hit(paddr, FULL_ACTION_IDX)) begin
         full_shadow_d = pwdata[15:0];
      end
      if (wr_en && hit(paddr, SIMPLE_ACTION_IDX)) begin
         simple_shadow_d = pwdata[15:0] & SIMPLE_WRITE_MASK;
      end
      if (wr_en && hit(paddr, FLAG_MASK_IDX)) begin
         mask_d = pwdata[5:0];
      end
      // protection wins over a simultaneous write
      if (prot_sync_q[1] == 1'b0) begin
         control_d[FULL_OE_BIT] = 1'b0;
         control_d[SIMPLE_OE_BIT] = 1'b0;
      end
      // loads happen on the event edge itself; a write then is seen at once
      full_active_d = ev.load_full ? full_shadow_d : full_active_q;
      simple_active_d = ev.load_simple ? simple_shadow_d : simple_active_q;
   end

   // =====================================================
   // flags: match delayed so the flag rises three clocks later
   always_comb begin
      flags_d = flags_q | (match_d2_q & {6{enable}});
      if (wr_en && hit(paddr, FLAG_STATUS_IDX)) begin
         // write one clears; a new set in the same cycle wins
         flags_d = (flags_q & ~pwdata[5:0]) | (match_d2_q & {6{enable}});
      end
   end

   always_comb begin
      rdata_d = rdata_q;
      if (rd_en) begin
         rdata_d = 32'h0000_0000;
         if (hit(paddr, COMPARE_CONTROL_IDX)) rdata_d[15:0] = control_q;
         if (hit(paddr, FULL_ACTION_IDX)) rdata_d[15:0] = full_shadow_q;
         if (hit(paddr, SIMPLE_ACTION_IDX)) rdata_d[15:0] = simple_shadow_q;
         if (hit(paddr, FLAG_STATUS_IDX)) rdata_d[5:0] = flags_q;
         if (hit(paddr, FLAG_MASK_IDX)) rdata_d[5:0] = mask_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_q <= REG_RESET;
         full_shadow_q <= REG_RESET;
         full_active_q <= REG_RESET;
         simple_shadow_q <= REG_RESET;
         simple_active_q <= REG_RESET;
         flags_q <= 6'h00;
         mask_q <= 6'h00;
         match_d1_q <= 6'h00;
         match_d2_q <= 6'h00;
         prot_sync_q <= 2'h3;
         rdata_q <= 32'h0000_0000;
      end else begin
         control_q <= control_d;
         full_shadow_q <= full_shadow_d;
         full_active_q <= full_active_d;
         simple_shadow_q <= simple_shadow_d;
         simple_active_q <= simple_active_d;
         flags_q <= flags_d;
         mask_q <= mask_d;
         match_d1_q <= {simple_match, full_match};
         match_d2_q <= match_d1_q;
         prot_sync_q <= {prot_sync_q[0], protect_n};
         rdata_q <= rdata_d;
      end
   end

   // =====================================================
   // pins: pair per full unit shares mode bit and waveform
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_full
         pin_action u_pin (
            .pclk(pclk),
            .presetn(presetn),
            .pwm_mode(control_q[MODE_LSB + g / 2]),
            .full_pin(1'b1),
            .action(full_active_q[2*g +: 2]),
            .match(full_match[g / 2]),
            .wave(full_wave[g / 2]),
            .enable(ev.enable),
            .level(full_out[g])
         );
      end
      for (g = 0; g < 3; g++) begin : g_simple
         pin_action u_pin (
            .pclk(pclk),
            .presetn(presetn),
            .pwm_mode(1'b1),
            .full_pin(1'b0),
            .action(simple_active_q[2*g +: 2]),
            .match(simple_match[g]),
            .wave(simple_wave[g]),
            .enable(ev.enable),
            .level(simple_out[g])
         );
      end
   endgenerate

   // outputs float after reset; full outputs also float while disabled
   assign full_out_oe_n = {6{~(control_q[FULL_OE_BIT] & enable)}};
   assign simple_out_oe_n = {3{~control_q[SIMPLE_OE_BIT]}};
   assign flag_pending = flags_q;
   assign irq = |(flags_q & mask_q);
   assign prdata = rdata_q;
endmodule // compare_action_pwm_outputs

// file: rtl/cmp_action_pkg.sv
// constants and types shared by the compare output action block
// =====================================================
// What this block does
// - bits 2..0 pick compare or PWM per full unit
// - full pin compare actions apply only while enabled
// - full action register has shadow and active copies
// - bit 15 holds space-vector rotation direction
// - bits 14..12 hold basic space-vector bits
// - two-bit action field per full pin
// - compare mode: hold, low, high, toggle
// - PWM mode: low, active low, active high, high
// - simple action register is double buffered
// - two-bit field per simple output
// - simple bits 15..6 read zero, ignore writes
// - one interrupt flag per compare unit
// - flag sets three clocks after match
// - reset zeroes registers, outputs high impedance
// - six full PWM channels leave this block
// - enable low makes shadows transparent
// - full reload: underflow, plus period, immediate
// - simple reload: zero, plus period, immediate
// - protection input clears full output enable
package cmp_action_pkg;
   // =====================================================
   // register map, word indices; apb byte address is four times the index
   localparam logic [15:0] COMPARE_CONTROL_IDX = 16'h7411;
   localparam logic [15:0] FULL_ACTION_IDX = 16'h7413;
   localparam logic [15:0] SIMPLE_ACTION_IDX = 16'h7414;
   localparam logic [15:0] FLAG_STATUS_IDX = 16'h7416;
   localparam logic [15:0] FLAG_MASK_IDX = 16'h7417;
   localparam int ADDR_W = 18;
   // =====================================================
   // compare control fields
   localparam int ENABLE_BIT = 15;
   localparam int FULL_RELOAD_LSB = 10;
   localparam int FULL_OE_BIT = 9;
   localparam int SIMPLE_OE_BIT = 8;
   localparam int SIMPLE_TIMER_BIT = 7;
   localparam int SIMPLE_RELOAD_LSB = 3;
   localparam int MODE_LSB = 0;
   // full action fields
   localparam int DIRECTION_BIT = 15;
   localparam int VECTOR_LSB = 12;
   localparam logic [15:0] SIMPLE_WRITE_MASK = 16'h003F;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // =====================================================
   // timing: flag delay after match
   localparam int FLAG_DELAY_CYCLES = 2;
   // =====================================================
   typedef enum logic [1:0] {
      act_hold_low = 2'h0,
      act_reset_active_low = 2'h1,
      act_set_active_high = 2'h2,
      act_toggle_high = 2'h3
   } action_type;
   typedef enum logic [1:0] {
      reload_zero = 2'h0,
      reload_zero_period = 2'h1,
      reload_now = 2'h2,
      reload_reserved = 2'h3
   } reload_type;
endpackage

// file: rtl/timer_event_if.sv
// timer events shared between the top and its output slices
`timescale 1ns/1ps
interface timer_event_if;
   logic load_full;
   logic load_simple;
   logic enable;
   modport source (output load_full, output load_simple, output enable);
   modport sink (input load_full, input load_simple, input enable);
endinterface

// file: rtl/pin_action.sv
// one output pin: applies a two-bit action in compare or PWM mode
`timescale 1ns/1ps
module pin_action (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic pwm_mode, // 1 pwm, 0 compare
   input wire logic full_pin, // 1 when pin may toggle on matches
   input wire logic [1:0] action, // active action field
   input wire logic match, // compare match pulse
   input wire logic wave, // raw pwm waveform
   input wire logic enable, // compare enable
   output logic level // pin level
);
   import cmp_action_pkg::*;
   logic level_q, level_d;
   always_comb begin
      level_d = level_q;
      if (pwm_mode || !full_pin) begin
         case (action_type'(action))
            act_hold_low: level_d = 1'b0;
            act_reset_active_low: level_d = ~wave;
            act_set_active_high: level_d = wave;
            default: level_d = 1'b1;
         endcase
      end else if (match && enable) begin
         case (action_type'(action))
            act_hold_low: level_d = level_q;
            act_reset_active_low: level_d = 1'b0;
            act_set_active_high: level_d = 1'b1;
            default: level_d = ~level_q;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level_d;
      end
   end
   assign level = level_q;
endmodule // pin_action

// file: rtl/reload_select.sv
// decodes a reload field against timer zero and period events
`timescale 1ns/1ps
module reload_select (
   input wire logic [1:0] sel, // reload field
   input wire logic zero, // timer at zero
   input wire logic period, // timer at period
   input wire logic enable, // compare enable
   output logic load // load shadow into active
);
   import cmp_action_pkg::*;
   always_comb begin
      if (!enable) begin
         load = 1'b1;
      end else begin
         case (reload_type'(sel))
            reload_zero: load = zero;
            reload_zero_period: load = zero | period;
            reload_now: load = 1'b1;
            default: load = 1'b0;
         endcase
      end
   end
endmodule // reload_select

// file: tb/cmp_action_props.sv
// assertion checker for the compare output action block
`timescale 1ns/1ps
module cmp_action_props (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [cmp_action_pkg::ADDR_W-1:0] paddr, // apb address
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic [2:0] full_match, // full unit matches
   input wire logic protect_n, // protection pin
   input wire logic [5:0] full_out_oe_n, // full enables
   input wire logic [2:0] simple_out_oe_n, // simple enables
   input wire logic [5:0] flag_pending, // unit flags
   input wire logic irq // interrupt summary
);
   import cmp_action_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====================================
   // named steps
   sequence armed_match;
      full_match[0] && !full_out_oe_n[0];
   endsequence
   sequence protect_held;
      !protect_n [*4];
   endsequence
   // =====================================
   // properties
   a_flag_delay: assert property (armed_match |-> ##[2:3] flag_pending[0])
      else $error("flag missed after match");
   a_flag_cause: assert property ($rose(flag_pending[0]) |-> $past(full_match[0], 2) || $past(full_match[0], 3))
      else $error("flag rose without match");
   a_reset_hiz: assert property ($rose(presetn) |-> &full_out_oe_n && &simple_out_oe_n)
      else $error("pins driven after reset");
   a_protect_hiz: assert property (protect_held |-> &full_out_oe_n && &simple_out_oe_n)
      else $error("pins driven under protection");
   a_oe_grouped: assert property (full_out_oe_n == {6{full_out_oe_n[0]}})
      else $error("full enables split");
   a_irq_source: assert property (irq |-> flag_pending != 6'h00)
      else $error("irq without flag");
   a_ready_now: assert property (psel && penable |-> pready)
      else $error("ready missing");
   a_err_phase: assert property (pslverr |-> psel && penable)
      else $error("error outside access");
   a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper half not zero");
   a_simple_rsvd: assert property (psel && penable && !pwrite && paddr == {SIMPLE_ACTION_IDX, 2'h0}
      |-> prdata[15:6] == 10'h000)
      else $error("reserved simple bits set");
endmodule // cmp_action_props

bind compare_action_pwm_outputs cmp_action_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .full_match, .protect_n, .full_out_oe_n, .simple_out_oe_n, .flag_pending, .irq);

// file: tb/switch_bank.sv
// power switch bank model driven by the compare outputs
`timescale 1ns/1ps
module switch_bank #(
   parameter int N = 6
) (
   input wire logic [N-1:0] level, // pin levels
   input wire logic [N-1:0] oe_n, // pin enables, low drives
   output logic [N-1:0] gate // gate seen by each switch
);
   // released pins fall to the gate pull-down, keeping the switch off
   assign gate = level & ~oe_n;
endmodule // switch_bank

// file: tb/compare_action_pwm_outputs_bench.sv
// self-checking bench for the compare output action block
`timescale 1ns/1ps
module compare_action_pwm_outputs_bench;
   import cmp_action_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, protect_n, irq, err;
   logic t1_zero, t1_period, t2_zero, t2_period;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] full_match, simple_match, full_wave, simple_wave, simple_out, simple_out_oe_n, simple_gate, exps;
   logic [5:0] full_out, full_out_oe_n, full_gate, flag_pending, expf;
   logic [1:0] cmp_code [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
   logic cmp_lvl [4] = '{1'h0, 1'h0, 1'h1, 1'h0};
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   compare_action_pwm_outputs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .full_match, .simple_match, .full_wave, .simple_wave, .t1_zero, .t1_period, .t2_zero, .t2_period,
      .protect_n, .full_out, .full_out_oe_n, .simple_out, .simple_out_oe_n, .flag_pending, .irq);
   switch_bank #(.N(6)) i_full_sw (.level(full_out), .oe_n(full_out_oe_n), .gate(full_gate));
   switch_bank #(.N(3)) i_simple_sw (.level(simple_out), .oe_n(simple_out_oe_n), .gate(simple_gate));
   // =====================================
   // clock and hang guard
   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         complete_run();
      end
   end
   // =====================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [15:0] idx, input logic wr, input logic [15:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, idx, 2'h0, 16'h0000, d};
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic pulse_ev(input logic [2:0] m, input logic z, input logic p);
      @(posedge pclk);
      {full_match, t1_zero, t1_period} <= {m, z, p};
      @(posedge pclk);
      {full_match, t1_zero, t1_period} <= '0;
   endtask
   // outputs are registered: let them settle before looking
   task automatic pins(input logic [5:0] f, input logic [2:0] s);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk(32'(full_gate), 32'(f));
      chk(32'(simple_gate), 32'(s));
   endtask
   function automatic logic lv(input logic [1:0] c, input logic w);
      return (c == 2'h3) || (c == 2'h2 && w) || (c == 2'h1 && !w);
   endfunction
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // =====================================
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, full_match, simple_match} = '0;
      {t1_zero, t1_period, t2_zero, t2_period} = '0;
      full_wave = 3'h5;
      simple_wave = 3'h2;
      protect_n = 1'h1;
      presetn = 1'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      pins(6'h00, 3'h0);
      chk(32'({full_out_oe_n, simple_out_oe_n}), 32'h1FF);
      apb(FULL_ACTION_IDX, 1'h0, 16'h0000);
      chk(rd, 32'h0);
      apb(FULL_ACTION_IDX, 1'h1, 16'hFFFF);
      apb(FULL_ACTION_IDX, 1'h0, 16'h0000);
      chk(rd, 32'hFFFF);
      apb(SIMPLE_ACTION_IDX, 1'h1, 16'hFFFF);
      apb(SIMPLE_ACTION_IDX, 1'h0, 16'h0000);
      chk(rd, 32'h3F);
      apb(16'h0000, 1'h0, 16'h0000);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(COMPARE_CONTROL_IDX, 1'h1, 16'h0B17);
      apb(COMPARE_CONTROL_IDX, 1'h1, 16'h8B17);
      for (int c = 0; c < 4; c++) begin
         apb(FULL_ACTION_IDX, 1'h1, {4'h0, {6{c[1:0]}}});
         apb(SIMPLE_ACTION_IDX, 1'h1, {10'h000, {3{c[1:0]}}});
         for (int i = 0; i < 6; i++) expf[i] = lv(c[1:0], full_wave[i/2]);
         for (int i = 0; i < 3; i++) exps[i] = lv(c[1:0], simple_wave[i]);
         pins(expf, exps);
      end
      apb(COMPARE_CONTROL_IDX, 1'h1, 16'h8307);
      apb(FULL_ACTION_IDX, 1'h1, 16'h0000);
      apb(SIMPLE_ACTION_IDX, 1'h1, 16'h0000);
      pins(6'h3F, 3'h7);
      pulse_ev(3'h0, 1'h1, 1'h0);
      pins(6'h00, 3'h0);
      apb(COMPARE_CONTROL_IDX, 1'h1, 16'h870F);
      apb(FULL_ACTION_IDX, 1'h1, 16'h0FFF);
      apb(SIMPLE_ACTION_IDX, 1'h1, 16'h003F);
      pulse_ev(3'h0, 1'h0, 1'h1);
      pins(6'h3F, 3'h7);
      // simple loads follow timer 2 once the time base bit is set
      apb(COMPARE_CONTROL_IDX, 1'h1, 16'h8387);
      apb(SIMPLE_ACTION_IDX, 1'h1, 16'h0000);
      pulse_ev(3'h0, 1'h1, 1'h0);
      pins(6'h3F, 3'h7);
      @(posedge pclk);
      t2_zero <= 1'h1;
      @(posedge pclk);
      t2_zero <= 1'h0;
      pins(6'h3F, 3'h0);
      apb(SIMPLE_ACTION_IDX, 1'h1, 16'h003F);
      apb(COMPARE_CONTROL_IDX, 1'h1, 16'h8B10);
      for (int k = 0; k < 4; k++) begin
         apb(FULL_ACTION_IDX, 1'h1, {4'h0, {6{cmp_code[k]}}});
         pulse_ev(3'h7, 1'h0, 1'h0);
         pins({6{cmp_lvl[k]}}, 3'h7);
      end
      chk(32'(flag_pending), 32'h07);
      apb(FLAG_MASK_IDX, 1'h1, 16'h0001);
      @(negedge pclk);
      chk(32'(irq), 32'h1);
      apb(FLAG_STATUS_IDX, 1'h1, 16'h0007);
      apb(FLAG_STATUS_IDX, 1'h0, 16'h0000);
      chk(rd, 32'h0);
      apb(COMPARE_CONTROL_IDX, 1'h1, 16'h0B10);
      pulse_ev(3'h7, 1'h0, 1'h0);
      pins(6'h00, 3'h7);
      chk(32'(full_out), 32'h00);
      chk(32'(flag_pending), 32'h00);
      apb(COMPARE_CONTROL_IDX, 1'h1, 16'h8B10);
      @(posedge pclk);
      protect_n <= 1'h0;
      repeat (6) @(posedge pclk);
      apb(COMPARE_CONTROL_IDX, 1'h0, 16'h0000);
      chk(rd, 32'h8810);
      chk(32'({full_out_oe_n, simple_out_oe_n}), 32'h1FF);
      protect_n <= 1'h1;
      complete_run();
   end
endmodule // compare_action_pwm_outputs_bench
